// *** core/rail_seq_pkg.sv ***
// Shared constants, carriers and state codes of the dual-rail sequencer
package rail_seq_pkg;

  // ==========================================================================
  // Timebase
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 5;

  // ==========================================================================
  // Timing figures and derived counts
  localparam int EN_FLT_US = 10;
  localparam int EN_FLT_CYC = (EN_FLT_US * 1000) / CLK_PERIOD_NS;
  localparam int FLT_W = 8;
  localparam int SS_MS = 5;
  localparam int SS_TICKS = (SS_MS * 1000000) / TICK_NS;
  localparam int FAULT_MS = 30;
  localparam int FAULT_TICKS = (FAULT_MS * 1000000) / TICK_NS;
  localparam int RETRY_MS = 1900;
  localparam int RETRY_TICKS = (RETRY_MS * 1000000) / TICK_NS;
  localparam int SHORT_US = 10;
  localparam int SHORT_TICKS = (SHORT_US * 1000) / TICK_NS;
  localparam int CNT_W = 21;
  localparam int SHORT_W = 8;

  // ==========================================================================
  // Reset values
  localparam logic [8:0] SYNC_RST = 9'h000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic uv;
    logic short_flag;
  } rail_flags_s;

  typedef struct packed {
    logic on;
    logic ramping;
    logic ready;
    logic faulted;
  } rail_status_s;

  // ==========================================================================
  // Rail controller states
  typedef enum logic [3:0] {
    R_OFF  = 4'b0001,
    R_SOFT = 4'b0010,
    R_RUN  = 4'b0100,
    R_WAIT = 4'b1000
  } rail_state_e;

endpackage : rail_seq_pkg

// *** core/rail_guard.sv ***
// One rail: soft-start, undervoltage and short timing, shutdown and retry
module rail_guard #(
  parameter int SS_TICKS = rail_seq_pkg::SS_TICKS,
  parameter int FAULT_TICKS = rail_seq_pkg::FAULT_TICKS,
  parameter int RETRY_TICKS = rail_seq_pkg::RETRY_TICKS,
  parameter int SHORT_TICKS = rail_seq_pkg::SHORT_TICKS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic request,
  input wire logic kill,
  input wire logic trip_in,
  input wire rail_seq_pkg::rail_flags_s flags,
  output logic trip_out,
  output rail_seq_pkg::rail_status_s status
);

  // ==========================================================================
  // Elaboration checks
  if (SS_TICKS < 1 || FAULT_TICKS < 1 || RETRY_TICKS < 1 ||
      RETRY_TICKS >= 2 ** rail_seq_pkg::CNT_W || SS_TICKS >= 2 ** rail_seq_pkg::CNT_W ||
      FAULT_TICKS >= 2 ** rail_seq_pkg::CNT_W) begin : g_bad_cnt
    $error("rail_guard: interval does not fit the counter");
  end
  if (SHORT_TICKS < 1 || SHORT_TICKS >= 2 ** rail_seq_pkg::SHORT_W) begin : g_bad_short
    $error("rail_guard: short delay does not fit its counter");
  end

  // ==========================================================================
  // State and counters
  rail_seq_pkg::rail_state_e state;
  rail_seq_pkg::rail_state_e next_state;
  logic [rail_seq_pkg::CNT_W-1:0] cnt;
  logic [rail_seq_pkg::SHORT_W-1:0] short_cnt;

  wire in_soft = (state == rail_seq_pkg::R_SOFT);
  wire in_run = (state == rail_seq_pkg::R_RUN);
  wire in_wait = (state == rail_seq_pkg::R_WAIT);
  wire ss_done = in_soft && tick && (cnt == rail_seq_pkg::CNT_W'(SS_TICKS - 1));
  wire uv_expired = in_run && flags.uv && tick &&
                    (cnt == rail_seq_pkg::CNT_W'(FAULT_TICKS - 1));
  // Short delay only counts in run, so the ramp never trips it
  wire short_expired = in_run && flags.short_flag && tick &&
                       (short_cnt == rail_seq_pkg::SHORT_W'(SHORT_TICKS - 1));
  wire retry_done = in_wait && tick && (cnt == rail_seq_pkg::CNT_W'(RETRY_TICKS - 1));
  wire stay = (next_state == state);
  wire entering_wait = (next_state == rail_seq_pkg::R_WAIT) && !in_wait;

  assign trip_out = uv_expired || short_expired;

  always_comb begin
    next_state = state;
    case (state)
      rail_seq_pkg::R_OFF: begin
        // A partner trip holds this rail off only in the cycle it fires; the rail may start while the partner waits
        if (request && !trip_in) next_state = rail_seq_pkg::R_SOFT;
      end
      rail_seq_pkg::R_SOFT: begin
        if (trip_in) next_state = rail_seq_pkg::R_WAIT;
        else if (ss_done) next_state = rail_seq_pkg::R_RUN;
      end
      rail_seq_pkg::R_RUN: begin
        if (trip_out || trip_in) next_state = rail_seq_pkg::R_WAIT;
      end
      rail_seq_pkg::R_WAIT: begin
        if (retry_done && !trip_in) next_state = rail_seq_pkg::R_SOFT;
      end
      default: next_state = rail_seq_pkg::R_OFF;
    endcase
    // Dropped enable stops any retry; kill turns the rail off at once
    if (!request || kill) next_state = rail_seq_pkg::R_OFF;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) state <= rail_seq_pkg::R_OFF;
    else state <= next_state;
  end

  // One counter serves ramp, undervoltage and retry; cleared on every state change
  always_ff @(posedge clk or posedge reset) begin
    if (reset) cnt <= '0;
    else if (!stay || state == rail_seq_pkg::R_OFF || (in_run && !flags.uv)) cnt <= '0;
    else if (tick) cnt <= cnt + 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) short_cnt <= '0;
    else if (!in_run || !flags.short_flag) short_cnt <= '0;
    else if (tick) short_cnt <= short_cnt + 1'b1;
  end

  // Fault stays flagged through retries until the rail runs clear of undervoltage or its request drops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= '0;
    end else begin
      status.on <= (next_state == rail_seq_pkg::R_SOFT) || (next_state == rail_seq_pkg::R_RUN);
      status.ramping <= (next_state == rail_seq_pkg::R_SOFT);
      status.ready <= (next_state == rail_seq_pkg::R_RUN);
      if (entering_wait) status.faulted <= 1'b1;
      else if ((in_run && !flags.uv) || !request) status.faulted <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  property p_off_when_dropped;
    @(posedge clk) disable iff (reset)
    !request |=> !status.on;
  endproperty
  a_off_when_dropped: assert property (p_off_when_dropped)
    else $error("rail stayed on after its request dropped");

  property p_uv_restart;
    @(posedge clk) disable iff (reset)
    (in_run && !flags.uv) |=> (cnt == '0);
  endproperty
  a_uv_restart: assert property (p_uv_restart)
    else $error("undervoltage count did not restart");

  property p_ramp_to_run;
    @(posedge clk) disable iff (reset)
    (ss_done && request && !kill && !trip_in) |=> (status.ready && !status.ramping);
  endproperty
  a_ramp_to_run: assert property (p_ramp_to_run)
    else $error("ramp end did not reach run");

  property p_trip_to_wait;
    @(posedge clk) disable iff (reset)
    (trip_out && request && !kill) |=> (in_wait && !status.on && status.faulted);
  endproperty
  a_trip_to_wait: assert property (p_trip_to_wait)
    else $error("timed-out rail was not shut off");

  property p_retry_start;
    @(posedge clk) disable iff (reset)
    (retry_done && request && !kill) |=> (status.ramping && status.faulted);
  endproperty
  a_retry_start: assert property (p_retry_start)
    else $error("retry did not restart the ramp");

  property p_short_after_ramp;
    @(posedge clk) disable iff (reset)
    !in_run |=> (short_cnt == '0);
  endproperty
  a_short_after_ramp: assert property (p_short_after_ramp)
    else $error("fault qualified before ramp end");

endmodule : rail_guard

// *** core/dual_rail_enable_fault_sequencer.sv ***
// Enable decode, mode selection and fault output of the dual-rail supply
// ==========================================================================
module dual_rail_enable_fault_sequencer #(
  parameter int SS_TICKS = rail_seq_pkg::SS_TICKS,
  parameter int FAULT_TICKS = rail_seq_pkg::FAULT_TICKS,
  parameter int RETRY_TICKS = rail_seq_pkg::RETRY_TICKS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic positive_rail_enable,
  input wire logic negative_rail_enable,
  input wire logic negative_feedback_strap,
  input wire logic core_ldo_good,
  input wire logic thermal_shutdown,
  input wire rail_seq_pkg::rail_flags_s positive_flags,
  input wire rail_seq_pkg::rail_flags_s negative_flags,
  output logic core_ldo_output_enable,
  output logic boost_output_node_enable,
  output logic switched_positive_rail_enable,
  output logic negative_rail_on,
  output logic positive_soft_start,
  output logic negative_soft_start,
  output logic tracking_mode,
  input wire logic fault_out_n_i,
  output logic fault_out_n_o,
  output logic fault_out_n_oe
);

  // ==========================================================================
  // Elaboration checks
  if (SS_TICKS < 1 || FAULT_TICKS < 1 || RETRY_TICKS < 1) begin : g_bad_time
    $error("dual_rail_enable_fault_sequencer: intervals must be at least one tick");
  end
  if (rail_seq_pkg::EN_FLT_CYC >= 2 ** rail_seq_pkg::FLT_W) begin : g_bad_flt
    $error("dual_rail_enable_fault_sequencer: filter count too wide");
  end

  // ==========================================================================
  // Input synchronisers
  // All inputs except the unused fault read-back are pins or analog comparators, so every one gets two flops
  logic [8:0] sync_a;
  logic [8:0] sync_b;
  wire [8:0] raw_in = {positive_rail_enable, negative_rail_enable, negative_feedback_strap,
                       core_ldo_good, thermal_shutdown, positive_flags, negative_flags};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_a <= rail_seq_pkg::SYNC_RST;
      sync_b <= rail_seq_pkg::SYNC_RST;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  wire [1:0] en_s = sync_b[8:7];
  wire strap_s = sync_b[6];
  wire ldo_good_s = sync_b[5];
  wire thermal_s = sync_b[4];
  rail_seq_pkg::rail_flags_s pos_flags_s;
  rail_seq_pkg::rail_flags_s neg_flags_s;
  assign pos_flags_s = sync_b[3:2];
  assign neg_flags_s = sync_b[1:0];

  // ==========================================================================
  // Free-running timebase
  logic [rail_seq_pkg::TICK_W-1:0] div_cnt;
  wire tick = (div_cnt == rail_seq_pkg::TICK_W'(rail_seq_pkg::TICK_CYC - 1));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) div_cnt <= '0;
    else if (tick) div_cnt <= '0;
    else div_cnt <= div_cnt + 1'b1;
  end

  // ==========================================================================
  // Enable deglitch
  // Bit 1 is the positive enable, bit 0 the negative one
  logic [1:0] en_f;

  for (genvar i = 0; i < 2; i++) begin : g_flt
    logic [rail_seq_pkg::FLT_W-1:0] flt_cnt;
    wire differs = (en_s[i] != en_f[i]);
    wire settled = differs &&
                   (flt_cnt == rail_seq_pkg::FLT_W'(rail_seq_pkg::EN_FLT_CYC - 1));

    // Any return to the old level before the count ends discards the pulse
    always_ff @(posedge clk or posedge reset) begin
      if (reset) flt_cnt <= '0;
      else if (!differs || settled) flt_cnt <= '0;
      else flt_cnt <= flt_cnt + 1'b1;
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) en_f[i] <= 1'b0;
      else if (settled) en_f[i] <= en_s[i];
    end
  end

  wire en_p_f = en_f[1];
  wire en_n_f = en_f[0];

  // ==========================================================================
  // Mode and enable decode
  wire any_en = en_p_f || en_n_f;
  // Rails wait one cycle behind the core regulator enable
  wire kill = !ldo_good_s || thermal_s;
  wire pos_req = en_p_f && core_ldo_output_enable;
  // Tracking needs the positive enable before the negative rail may run
  wire neg_req = (strap_s ? (en_p_f && en_n_f) : en_n_f) && core_ldo_output_enable;
  wire pos_trip;
  wire neg_trip;
  // Tracking ties the two rails' trips together; independent keeps them apart
  wire pos_trip_in = strap_s && neg_trip;
  wire neg_trip_in = strap_s && pos_trip;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_ldo_output_enable <= 1'b0;
      tracking_mode <= 1'b0;
    end else begin
      core_ldo_output_enable <= any_en;
      tracking_mode <= strap_s;
    end
  end

  // ==========================================================================
  // Rail controllers
  rail_seq_pkg::rail_status_s pos_st;
  rail_seq_pkg::rail_status_s neg_st;

  rail_guard #(
    .SS_TICKS(SS_TICKS),
    .FAULT_TICKS(FAULT_TICKS),
    .RETRY_TICKS(RETRY_TICKS),
    .SHORT_TICKS(rail_seq_pkg::SHORT_TICKS)
  ) u_pos (
    .clk(clk),
    .reset(reset),
    .tick(tick),
    .request(pos_req),
    .kill(kill),
    .trip_in(pos_trip_in),
    .flags(pos_flags_s),
    .trip_out(pos_trip),
    .status(pos_st)
  );

  rail_guard #(
    .SS_TICKS(SS_TICKS),
    .FAULT_TICKS(FAULT_TICKS),
    .RETRY_TICKS(RETRY_TICKS),
    .SHORT_TICKS(rail_seq_pkg::SHORT_TICKS)
  ) u_neg (
    .clk(clk),
    .reset(reset),
    .tick(tick),
    .request(neg_req),
    .kill(kill),
    .trip_in(neg_trip_in),
    .flags(neg_flags_s),
    .trip_out(neg_trip),
    .status(neg_st)
  );

  // ==========================================================================
  // Rail outputs
  // Output switch closes only after the boost node has ramped, sparing its charge
  assign boost_output_node_enable = pos_st.on;
  assign switched_positive_rail_enable = pos_st.ready;
  assign negative_rail_on = neg_st.on;
  assign positive_soft_start = pos_st.ramping;
  assign negative_soft_start = neg_st.ramping;

  // ==========================================================================
  // Open-drain fault output
  // The pin is only ever pulled low; the line level read back is not used
  logic fault_drive;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) fault_drive <= 1'b0;
    else fault_drive <= thermal_s || pos_st.faulted || neg_st.faulted;
  end

  assign fault_out_n_o = 1'b0;
  assign fault_out_n_oe = fault_drive;

  // ==========================================================================
  // Assertions
  property p_idle;
    @(posedge clk) disable iff (reset)
    (!en_p_f && !en_n_f) |=> !core_ldo_output_enable ##1 (!boost_output_node_enable &&
                                                          !negative_rail_on);
  endproperty
  a_idle: assert property (p_idle)
    else $error("rails or core regulator active while both enables low");

  property p_core_first;
    @(posedge clk) disable iff (reset)
    $rose(core_ldo_output_enable) |-> (!boost_output_node_enable && !negative_rail_on);
  endproperty
  a_core_first: assert property (p_core_first)
    else $error("rail came up before the core regulator enable");

  property p_core_bad;
    @(posedge clk) disable iff (reset)
    !ldo_good_s |=> (!boost_output_node_enable && !negative_rail_on &&
                     !switched_positive_rail_enable);
  endproperty
  a_core_bad: assert property (p_core_bad)
    else $error("rail on while core regulator out of range");

  property p_track_pos_low;
    @(posedge clk) disable iff (reset)
    (strap_s && !en_p_f) |=> !negative_rail_on;
  endproperty
  a_track_pos_low: assert property (p_track_pos_low)
    else $error("negative rail on in tracking mode without positive enable");

  property p_thermal_off;
    @(posedge clk) disable iff (reset)
    thermal_s |=> (!boost_output_node_enable && !negative_rail_on && fault_out_n_oe);
  endproperty
  a_thermal_off: assert property (p_thermal_off)
    else $error("thermal shutdown did not stop rails and flag fault");

  property p_fault_held;
    @(posedge clk) disable iff (reset)
    (pos_st.faulted || neg_st.faulted) |=> fault_out_n_oe;
  endproperty
  a_fault_held: assert property (p_fault_held)
    else $error("fault output released during retry");

  property p_track_both_off;
    @(posedge clk) disable iff (reset)
    (strap_s && pos_trip && !kill) |=> (!boost_output_node_enable && !negative_rail_on);
  endproperty
  a_track_both_off: assert property (p_track_both_off)
    else $error("tracking trip left a rail running");

  property p_deglitch;
    @(posedge clk) disable iff (reset)
    $rose(en_p_f) |-> ($past(en_s[1], 1) && $past(en_s[1], 8));
  endproperty
  a_deglitch: assert property (p_deglitch)
    else $error("positive enable accepted without a stable level");

  property p_tick_period;
    @(posedge clk) disable iff (reset)
    tick |=> !tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("timebase tick not a single-cycle pulse");

endmodule : dual_rail_enable_fault_sequencer

// *** dv/rail_panel_model.sv ***
// Panel supply rails seen by the sequencer: sag comparators per rail
module rail_panel_model (
  input wire logic pos_on,
  input wire logic pos_ramp,
  input wire logic neg_on,
  input wire logic neg_ramp,
  input wire logic pos_sag,
  input wire logic neg_sag,
  input wire logic pos_short,
  output rail_seq_pkg::rail_flags_s positive_flags,
  output rail_seq_pkg::rail_flags_s negative_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Comparators
  // An unpowered or ramping rail really sits below threshold, so uv is high then
  assign positive_flags = '{uv: !pos_on | pos_ramp | pos_sag, short_flag: pos_short};
  assign negative_flags = '{uv: !neg_on | neg_ramp | neg_sag, short_flag: 1'b0};
endmodule : rail_panel_model

// *** dv/dual_rail_enable_fault_sequencer_bench.sv ***
// Self-checking bench of the dual-rail enable and fault sequencer
`define CHECK(what, exp, got) \
  checks++; \
  if ((got) !== (exp)) begin \
    $display("MISMATCH %s exp=%0h got=%0h", what, exp, got); \
    err_count++; \
  end
module dual_rail_enable_fault_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  localparam int I_LDO = 0, I_BST = 1, I_SW = 2, I_NEG = 3;
  localparam int I_PSS = 4, I_NSS = 5, I_TRK = 6, I_FLT = 7;
  logic clk = 1'b0, reset = 1'b1;
  logic pos_en = 1'b0, neg_en = 1'b0, strap = 1'b0, ldo_good = 1'b1, thermal = 1'b0;
  logic pos_sag = 1'b0, neg_sag = 1'b0, pos_short = 1'b0;
  rail_seq_pkg::rail_flags_s positive_flags, negative_flags;
  logic ldo_en, bst_en, sw_en, neg_on, pss, nss, trk, flt_o, flt_oe;
  wire fault_line = flt_oe ? flt_o : 1'b1;
  wire [7:0] obs = {fault_line, trk, nss, pss, neg_on, sw_en, bst_en, ldo_en};
  int err_count = 0;
  int checks = 0;
  // ==========================================================================
  // Design and rails
  // Short counts keep retry cycles within a few hundred clocks
  dual_rail_enable_fault_sequencer #(.SS_TICKS(4), .FAULT_TICKS(6), .RETRY_TICKS(10)) u_dut (
    .clk(clk), .reset(reset), .positive_rail_enable(pos_en), .negative_rail_enable(neg_en),
    .negative_feedback_strap(strap), .core_ldo_good(ldo_good), .thermal_shutdown(thermal),
    .positive_flags(positive_flags), .negative_flags(negative_flags),
    .core_ldo_output_enable(ldo_en), .boost_output_node_enable(bst_en),
    .switched_positive_rail_enable(sw_en), .negative_rail_on(neg_on),
    .positive_soft_start(pss), .negative_soft_start(nss), .tracking_mode(trk),
    .fault_out_n_i(fault_line), .fault_out_n_o(flt_o), .fault_out_n_oe(flt_oe));
  rail_panel_model u_rails (
    .pos_on(bst_en), .pos_ramp(pss), .neg_on(neg_on), .neg_ramp(nss),
    .pos_sag(pos_sag), .neg_sag(neg_sag), .pos_short(pos_short),
    .positive_flags(positive_flags), .negative_flags(negative_flags));
  // ==========================================================================
  // Helpers
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input int idx, input logic v, input string what);
    `CHECK(what, v, obs[idx])
  endtask : chk
  // Bounded wait sampled at falling edges, where outputs are settled
  task automatic wait_obs(input int idx, input logic v, input int n, input string what);
    for (int i = 0; i < n && obs[idx] !== v; i++) @(negedge clk);
    `CHECK(what, v, obs[idx])
  endtask : wait_obs
  task automatic set_en(input logic p, input logic n);
    @(negedge clk);
    pos_en = p;
    neg_en = n;
  endtask : set_en
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic summarize();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // ==========================================================================
  // Scenarios
  task automatic t_idle_glitch();
    idle(300);
    `CHECK("idle outputs", 8'h80, obs)
    set_en(1'b1, 1'b0);
    idle(100);
    set_en(1'b0, 1'b0);
    idle(400);
    chk(I_LDO, 1'b0, "short pulse ignored");
  endtask : t_idle_glitch
  task automatic t_independent();
    set_en(1'b1, 1'b0);
    wait_obs(I_LDO, 1'b1, 400, "core on");
    wait_obs(I_BST, 1'b1, 5, "boost after core");
    chk(I_PSS, 1'b1, "pos ramping");
    chk(I_SW, 1'b0, "switch open in ramp");
    chk(I_NEG, 1'b0, "neg stays off");
    wait_obs(I_SW, 1'b1, 200, "switch after ramp");
    chk(I_PSS, 1'b0, "pos ramp done");
    set_en(1'b1, 1'b1);
    wait_obs(I_NSS, 1'b1, 400, "neg ramping");
    chk(I_NEG, 1'b1, "neg on");
    wait_obs(I_NSS, 1'b0, 200, "neg ramp done");
    set_en(1'b0, 1'b1);
    wait_obs(I_BST, 1'b0, 400, "pos off alone");
    chk(I_NEG, 1'b1, "neg kept");
    set_en(1'b0, 1'b0);
    idle(400);
    `CHECK("all off", 8'h80, obs)
  endtask : t_independent
  task automatic t_tracking();
    strap = 1'b1;
    idle(10);
    chk(I_TRK, 1'b1, "tracking mode");
    set_en(1'b0, 1'b1);
    idle(400);
    chk(I_NEG, 1'b0, "neg off without pos");
    chk(I_BST, 1'b0, "boost off without pos");
    set_en(1'b1, 1'b1);
    wait_obs(I_SW, 1'b1, 700, "tracked switch on");
    chk(I_NEG, 1'b1, "tracked neg on");
    idle(100);
    neg_sag = 1'b1;
    wait_obs(I_NEG, 1'b0, 400, "neg off after timeout");
    chk(I_BST, 1'b0, "boost off too");
    wait_obs(I_FLT, 1'b0, 3, "fault line low");
    wait_obs(I_BST, 1'b1, 400, "retry boost");
    chk(I_NEG, 1'b1, "retry neg");
    chk(I_FLT, 1'b0, "fault held in retry");
    neg_sag = 1'b0;
    wait_obs(I_SW, 1'b1, 200, "resumed");
    wait_obs(I_FLT, 1'b1, 10, "fault released");
    set_en(1'b0, 1'b0);
    idle(400);
    strap = 1'b0;
  endtask : t_tracking
  task automatic t_indep_fault();
    set_en(1'b1, 1'b1);
    wait_obs(I_SW, 1'b1, 700, "both on");
    wait_obs(I_NSS, 1'b0, 200, "neg ramp done");
    pos_sag = 1'b1;
    wait_obs(I_SW, 1'b0, 400, "pos shut");
    chk(I_NEG, 1'b1, "neg left running");
    wait_obs(I_FLT, 1'b0, 3, "fault low");
    wait_obs(I_BST, 1'b1, 400, "pos retried");
    // Sag still present: the retried ramp ends but the fault must stay flagged
    wait_obs(I_SW, 1'b1, 200, "retry ramp done");
    chk(I_FLT, 1'b0, "fault held after retry ramp");
    set_en(1'b0, 1'b1);
    idle(700);
    chk(I_BST, 1'b0, "retry stopped");
    chk(I_FLT, 1'b1, "fault cleared on drop");
    pos_sag = 1'b0;
    set_en(1'b0, 1'b0);
    idle(400);
  endtask : t_indep_fault
  task automatic t_short();
    set_en(1'b1, 1'b0);
    wait_obs(I_PSS, 1'b1, 400, "short ramp");
    pos_short = 1'b1;
    wait_obs(I_SW, 1'b1, 200, "short ignored in ramp");
    chk(I_FLT, 1'b1, "no fault in ramp");
    wait_obs(I_SW, 1'b0, 400, "short trips in run");
    wait_obs(I_FLT, 1'b0, 3, "short fault");
    pos_short = 1'b0;
    set_en(1'b0, 1'b0);
    idle(400);
  endtask : t_short
  task automatic t_thermal_ldo();
    set_en(1'b1, 1'b1);
    wait_obs(I_SW, 1'b1, 700, "both on");
    thermal = 1'b1;
    wait_obs(I_BST, 1'b0, 5, "thermal off");
    chk(I_NEG, 1'b0, "thermal neg off");
    wait_obs(I_FLT, 1'b0, 3, "thermal fault");
    thermal = 1'b0;
    wait_obs(I_BST, 1'b1, 10, "thermal restart");
    chk(I_NEG, 1'b1, "thermal neg restart");
    ldo_good = 1'b0;
    wait_obs(I_BST, 1'b0, 5, "core bad halts");
    idle(300);
    chk(I_NEG, 1'b0, "core bad holds off");
    ldo_good = 1'b1;
    set_en(1'b0, 1'b0);
    idle(400);
  endtask : t_thermal_ldo
  // ==========================================================================
  // Sequence and watchdog
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_idle_glitch();
    t_independent();
    t_tracking();
    t_indep_fault();
    t_short();
    t_thermal_ldo();
    summarize();
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule : dual_rail_enable_fault_sequencer_bench
